// [src/mil_pkg.sv]
package mil_pkg;
	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int NUM_AXES = 8;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [3:0] OFS_FORCE_ON = 4'h0;
	localparam logic [3:0] OFS_FORCE_OFF = 4'h1;
	localparam logic [3:0] OFS_APPLY = 4'h2;
	localparam logic [3:0] OFS_INH_STATE = 4'h3;
	localparam logic [3:0] OFS_INH_AXIS_EN = 4'h4;
	localparam logic [3:0] OFS_INH_POL = 4'h5;
	localparam logic [3:0] OFS_FWD_POL = 4'h6;
	localparam logic [3:0] OFS_REV_POL = 4'h7;
	localparam logic [3:0] OFS_LIM_EN = 4'h8;
	localparam logic [3:0] OFS_FWD_STAT = 4'h9;
	localparam logic [3:0] OFS_REV_STAT = 4'ha;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_LIM_POL = 8'hff;
	localparam logic [7:0] RST_INH_POL = 8'h00;
	localparam logic [7:0] RST_LIM_EN = 8'h00;
	localparam logic [7:0] RST_AXIS_EN = 8'h00;
endpackage

// [src/mil_limit_qual.sv]
module mil_limit_qual (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins and settings
	input wire logic [7:0] pin,
	input wire logic [7:0] pol_low,
	input wire logic [7:0] enable,
	// results
	output logic [7:0] active_r,
	output logic [7:0] halt_r
);
	logic [7:0] active_nxt;

	// ----------------------------------------
	// per-axis polarity qualification
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < mil_pkg::NUM_AXES; g++) begin : g_ax
			// low selected: active when pin low; else when high
			assign active_nxt[g] = pol_low[g] ? ~pin[g] : pin[g];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			active_r <= mil_pkg::RST_ZERO;
		end else begin
			active_r <= active_nxt;
		end
	end

	// halt only on the transition to active, as a one-cycle pulse
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			halt_r <= mil_pkg::RST_ZERO;
		end else begin
			halt_r <= active_nxt & ~active_r & enable;
		end
	end

	a_halt_cause: assert property (@(posedge clk) disable iff (!rst_n)
		halt_r[0] |-> active_r[0] && !$past(active_r[0]) && $past(enable[0]))
		else $error("halt without a fresh enabled limit");
	a_qual_low: assert property (@(posedge clk) disable iff (!rst_n)
		(pol_low[1] && !pin[1]) |=> active_r[1])
		else $error("active-low limit not seen");
	a_qual_high: assert property (@(posedge clk) disable iff (!rst_n)
		(!pol_low[2] && pin[2]) |=> active_r[2])
		else $error("active-high limit not seen");
endmodule

// [src/mil_top.sv]
// What this block does
// - force-on bit drives inhibit output On
// - force-off bit drives output Off otherwise
// - both bits clear keeps output state
// - both bits set means force-on
// - axis-enabled outputs ignore forcing, follow axis
// - pin level follows inhibit polarity setting
// - separate forward and reverse limit polarities
// - set polarity bit means active low, resets set
// - active low: limit active on low pin
// - active high: limit active on high pin
// - enabled limit going active issues halt
// - qualified limit state always readable
//
// The register offsets and the address-and-strobe port were decided locally.
module mil_top (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// register port
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// axis side
	input wire logic [7:0] AXIS_INHIBIT,
	input wire logic [7:0] FWD_LIMIT,
	input wire logic [7:0] REV_LIMIT,
	// pins and halts
	output logic [7:0] INHIBIT_PIN,
	output logic [7:0] HALT
);
	logic [7:0] force_on_r;
	logic [7:0] force_off_r;
	logic [7:0] inh_state_r;
	logic [7:0] inh_state_nxt;
	logic [7:0] axis_en_r;
	logic [7:0] inh_pol_r;
	logic [7:0] fwd_pol_r;
	logic [7:0] rev_pol_r;
	logic [7:0] lim_en_r;
	logic [7:0] fwd_act;
	logic [7:0] rev_act;
	logic [7:0] fwd_halt;
	logic [7:0] rev_halt;
	logic [7:0] rdata_nxt;
	logic apply;
	logic [7:0] logical;

	assign apply = WR && (ADDR == mil_pkg::OFS_APPLY);

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			force_on_r <= mil_pkg::RST_ZERO;
			force_off_r <= mil_pkg::RST_ZERO;
			axis_en_r <= mil_pkg::RST_AXIS_EN;
			inh_pol_r <= mil_pkg::RST_INH_POL;
			fwd_pol_r <= mil_pkg::RST_LIM_POL;
			rev_pol_r <= mil_pkg::RST_LIM_POL;
			lim_en_r <= mil_pkg::RST_LIM_EN;
		end else if (WR) begin
			unique case (ADDR)
				mil_pkg::OFS_FORCE_ON: force_on_r <= WDATA;
				mil_pkg::OFS_FORCE_OFF: force_off_r <= WDATA;
				mil_pkg::OFS_INH_AXIS_EN: axis_en_r <= WDATA;
				mil_pkg::OFS_INH_POL: inh_pol_r <= WDATA;
				mil_pkg::OFS_FWD_POL: fwd_pol_r <= WDATA;
				mil_pkg::OFS_REV_POL: rev_pol_r <= WDATA;
				mil_pkg::OFS_LIM_EN: lim_en_r <= WDATA;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// force set/clear protocol
	// ----------------------------------------
	// masks are staged first, then one apply strobe acts on all bits
	// together, so no partial pattern reaches the pins
	genvar g;
	generate
		for (g = 0; g < mil_pkg::NUM_AXES; g++) begin : g_force
			logic bit_nxt;

			always_comb begin
				if (!apply) begin
					bit_nxt = inh_state_r[g];
				end else if (axis_en_r[g]) begin
					bit_nxt = inh_state_r[g];
				end else if (force_on_r[g]) begin
					bit_nxt = 1'b1;
				end else if (force_off_r[g]) begin
					bit_nxt = 1'b0;
				end else begin
					bit_nxt = inh_state_r[g];
				end
			end

			assign inh_state_nxt[g] = bit_nxt;

			// per-output checks, one set for every bit
			a_bit_on: assert property (@(posedge CLK) disable iff (!RST_N)
				(apply && force_on_r[g] && !axis_en_r[g]) |=> inh_state_r[g])
				else $error("forced-on output not on");
			a_bit_off: assert property (@(posedge CLK) disable iff (!RST_N)
				(apply && !force_on_r[g] && force_off_r[g] && !axis_en_r[g]) |=> !inh_state_r[g])
				else $error("forced-off output not off");
			a_bit_hold: assert property (@(posedge CLK) disable iff (!RST_N)
				(!apply || (!force_on_r[g] && !force_off_r[g])) |=> $stable(inh_state_r[g]))
				else $error("output state moved without a request");
			// axis-enabled bits keep their state; the pin follows the axis
			a_bit_axis: assert property (@(posedge CLK) disable iff (!RST_N)
				axis_en_r[g] |=> $stable(inh_state_r[g]))
				else $error("axis-enabled output was forced");
			a_bit_pin: assert property (@(posedge CLK) disable iff (!RST_N)
				!$past(axis_en_r[g]) |-> INHIBIT_PIN[g] == (inh_state_r[g] ^ $past(inh_pol_r[g])))
				else $error("forced pin level wrong for polarity");
			a_bit_follow: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(axis_en_r[g]) |-> INHIBIT_PIN[g] == ($past(AXIS_INHIBIT[g]) ^ $past(inh_pol_r[g])))
				else $error("axis-enabled pin does not follow its axis");
		end
	endgenerate

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			inh_state_r <= mil_pkg::RST_ZERO;
		end else begin
			inh_state_r <= inh_state_nxt;
		end
	end

	// ----------------------------------------
	// inhibit pins
	// ----------------------------------------
	assign logical = (axis_en_r & AXIS_INHIBIT) | (~axis_en_r & inh_state_nxt);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			INHIBIT_PIN <= mil_pkg::RST_ZERO;
		end else begin
			// polarity bit set means active low pin
			INHIBIT_PIN <= logical ^ inh_pol_r;
		end
	end

	// ----------------------------------------
	// limit qualification
	// ----------------------------------------
	mil_limit_qual u_fwd (
		.clk(CLK),
		.rst_n(RST_N),
		.pin(FWD_LIMIT),
		.pol_low(fwd_pol_r),
		.enable(lim_en_r),
		.active_r(fwd_act),
		.halt_r(fwd_halt)
	);

	mil_limit_qual u_rev (
		.clk(CLK),
		.rst_n(RST_N),
		.pin(REV_LIMIT),
		.pol_low(rev_pol_r),
		.enable(lim_en_r),
		.active_r(rev_act),
		.halt_r(rev_halt)
	);

	// one halt per axis for either direction
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			HALT <= mil_pkg::RST_ZERO;
		end else begin
			HALT <= fwd_halt | rev_halt;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_comb begin
		rdata_nxt = mil_pkg::RST_ZERO;
		unique case (ADDR)
			mil_pkg::OFS_FORCE_ON: rdata_nxt = force_on_r;
			mil_pkg::OFS_FORCE_OFF: rdata_nxt = force_off_r;
			mil_pkg::OFS_INH_STATE: rdata_nxt = inh_state_r;
			mil_pkg::OFS_INH_AXIS_EN: rdata_nxt = axis_en_r;
			mil_pkg::OFS_INH_POL: rdata_nxt = inh_pol_r;
			mil_pkg::OFS_FWD_POL: rdata_nxt = fwd_pol_r;
			mil_pkg::OFS_REV_POL: rdata_nxt = rev_pol_r;
			mil_pkg::OFS_LIM_EN: rdata_nxt = lim_en_r;
			// readable regardless of the enable
			mil_pkg::OFS_FWD_STAT: rdata_nxt = fwd_act;
			mil_pkg::OFS_REV_STAT: rdata_nxt = rev_act;
			default: rdata_nxt = mil_pkg::RST_ZERO;
		endcase
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			RDATA <= mil_pkg::RST_ZERO;
		end else if (RD) begin
			RDATA <= rdata_nxt;
		end else begin
			RDATA <= mil_pkg::RST_ZERO;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_force_on_wins: assert property (@(posedge CLK) disable iff (!RST_N)
		(apply && force_on_r[0] && !axis_en_r[0]) |=> inh_state_r[0])
		else $error("force-on did not turn output on");
	a_force_off: assert property (@(posedge CLK) disable iff (!RST_N)
		(apply && !force_on_r[1] && force_off_r[1] && !axis_en_r[1]) |=> !inh_state_r[1])
		else $error("force-off did not turn output off");
	a_hold_state: assert property (@(posedge CLK) disable iff (!RST_N)
		(!apply || (!force_on_r[2] && !force_off_r[2])) |=> $stable(inh_state_r[2]))
		else $error("output state changed without request");
	a_axis_ignores: assert property (@(posedge CLK) disable iff (!RST_N)
		axis_en_r[3] |=> $stable(inh_state_r[3]))
		else $error("axis-enabled output was forced");
	a_pin_polarity: assert property (@(posedge CLK) disable iff (!RST_N)
		(!axis_en_r[4] && !$past(axis_en_r[4]) && $stable(inh_pol_r))
		|-> INHIBIT_PIN[4] == (inh_state_r[4] ^ $past(inh_pol_r[4])))
		else $error("inhibit pin level wrong for polarity");
	a_pol_reset: assert property (@(posedge CLK)
		!RST_N |=> (fwd_pol_r == mil_pkg::RST_LIM_POL) && (rev_pol_r == mil_pkg::RST_LIM_POL))
		else $error("limit polarity not reset to active low");
	a_halt_enabled: assert property (@(posedge CLK) disable iff (!RST_N)
		(HALT & ~$past(lim_en_r, 2)) == mil_pkg::RST_ZERO)
		else $error("halt on a disabled axis");
	a_read_stat: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && ADDR == mil_pkg::OFS_FWD_STAT) |=> RDATA == $past(fwd_act))
		else $error("limit status read wrong");
	a_read_rev_stat: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && ADDR == mil_pkg::OFS_REV_STAT) |=> RDATA == $past(rev_act))
		else $error("reverse limit status read wrong");
	a_read_state: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && ADDR == mil_pkg::OFS_INH_STATE) |=> RDATA == $past(inh_state_r))
		else $error("inhibit state read wrong");
	a_rdata_idle: assert property (@(posedge CLK) disable iff (!RST_N)
		!RD |=> RDATA == mil_pkg::RST_ZERO)
		else $error("read data stands outside its cycle");

	// ----------------------------------------
	// force checks
	// ----------------------------------------
	a_apply_all: assert property (@(posedge CLK) disable iff (!RST_N)
		apply |=> inh_state_r == (($past(inh_state_r)
			& ($past(axis_en_r) | ~($past(force_on_r) | $past(force_off_r))))
			| (~$past(axis_en_r) & $past(force_on_r))))
		else $error("masks not applied to all outputs together");
	a_state_ro: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == mil_pkg::OFS_INH_STATE) |=> $stable(inh_state_r))
		else $error("status index write changed output state");
	a_pol_no_state: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == mil_pkg::OFS_INH_POL) |=> $stable(inh_state_r))
		else $error("polarity write changed logical state");

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	a_wr_force_on: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == mil_pkg::OFS_FORCE_ON) |=> force_on_r == $past(WDATA))
		else $error("force-on mask write lost");
	a_wr_force_off: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == mil_pkg::OFS_FORCE_OFF) |=> force_off_r == $past(WDATA))
		else $error("force-off mask write lost");
	a_wr_axis_en: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == mil_pkg::OFS_INH_AXIS_EN) |=> axis_en_r == $past(WDATA))
		else $error("axis enable write lost");
	a_wr_inh_pol: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == mil_pkg::OFS_INH_POL) |=> inh_pol_r == $past(WDATA))
		else $error("inhibit polarity write lost");
	a_wr_fwd_pol: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == mil_pkg::OFS_FWD_POL) |=> fwd_pol_r == $past(WDATA))
		else $error("forward polarity write lost");
	a_wr_rev_pol: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == mil_pkg::OFS_REV_POL) |=> rev_pol_r == $past(WDATA))
		else $error("reverse polarity write lost");
	a_wr_lim_en: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == mil_pkg::OFS_LIM_EN) |=> lim_en_r == $past(WDATA))
		else $error("limit enable write lost");
	a_fwd_pol_apart: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == mil_pkg::OFS_FWD_POL) |=> $stable(rev_pol_r))
		else $error("forward polarity write touched reverse");
	a_rev_pol_apart: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == mil_pkg::OFS_REV_POL) |=> $stable(fwd_pol_r))
		else $error("reverse polarity write touched forward");
	// indexes past the last register must not alias onto a setting
	a_unmapped_wr: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR > mil_pkg::OFS_REV_STAT) |=> $stable(force_on_r) && $stable(force_off_r)
			&& $stable(axis_en_r) && $stable(inh_pol_r) && $stable(lim_en_r)
			&& $stable(fwd_pol_r) && $stable(rev_pol_r))
		else $error("write to an unused index changed a setting");

	// ----------------------------------------
	// reset
	// ----------------------------------------
	a_reset_out: assert property (@(posedge CLK)
		!RST_N |=> (INHIBIT_PIN == mil_pkg::RST_ZERO) && (HALT == mil_pkg::RST_ZERO)
			&& (RDATA == mil_pkg::RST_ZERO))
		else $error("outputs not cleared by reset");
	a_reset_cfg: assert property (@(posedge CLK)
		!RST_N |=> (force_on_r == mil_pkg::RST_ZERO) && (force_off_r == mil_pkg::RST_ZERO)
			&& (inh_state_r == mil_pkg::RST_ZERO) && (axis_en_r == mil_pkg::RST_AXIS_EN)
			&& (inh_pol_r == mil_pkg::RST_INH_POL) && (lim_en_r == mil_pkg::RST_LIM_EN))
		else $error("settings not cleared by reset");

	// ----------------------------------------
	// limit checks per axis
	// ----------------------------------------
	genvar h;
	generate
		for (h = 0; h < mil_pkg::NUM_AXES; h++) begin : g_lim_chk
			a_halt_fires: assert property (@(posedge CLK) disable iff (!RST_N)
				($past(lim_en_r[h]) && fwd_act[h] && !$past(fwd_act[h])) |=> HALT[h])
				else $error("enabled forward limit gave no halt");
			a_halt_fires_rev: assert property (@(posedge CLK) disable iff (!RST_N)
				($past(lim_en_r[h]) && rev_act[h] && !$past(rev_act[h])) |=> HALT[h])
				else $error("enabled reverse limit gave no halt");
			a_halt_source: assert property (@(posedge CLK) disable iff (!RST_N)
				HALT[h] |-> ($past(fwd_act[h]) && !$past(fwd_act[h], 2))
					|| ($past(rev_act[h]) && !$past(rev_act[h], 2)))
				else $error("halt without a fresh limit");
			a_stat_fwd: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) |-> fwd_act[h]
					== ($past(fwd_pol_r[h]) ? !$past(FWD_LIMIT[h]) : $past(FWD_LIMIT[h])))
				else $error("forward limit qualified wrongly");
			a_stat_rev: assert property (@(posedge CLK) disable iff (!RST_N)
				$past(RST_N) |-> rev_act[h]
					== ($past(rev_pol_r[h]) ? !$past(REV_LIMIT[h]) : $past(REV_LIMIT[h])))
				else $error("reverse limit qualified wrongly");
		end
	endgenerate
endmodule

// [sim/mil_axis_model.sv]
module mil_axis_model (
	// clock
	input wire logic clk,
	// bench commands
	input wire logic [7:0] fwd_cmd,
	input wire logic [7:0] rev_cmd,
	input wire logic [7:0] inh_cmd,
	// switch and axis lines into the block
	output logic [7:0] fwd_pin,
	output logic [7:0] rev_pin,
	output logic [7:0] axis_inh
);
	timeunit 1ns;
	timeprecision 1ps;
	// switches open at start: pins sit high, axes idle
	initial begin
		fwd_pin = 8'hff;
		rev_pin = 8'hff;
		axis_inh = 8'h00;
	end
	// lines move just after an edge, like real synchronised inputs
	always @(posedge clk) begin
		fwd_pin <= fwd_cmd;
		rev_pin <= rev_cmd;
		axis_inh <= inh_cmd;
	end
endmodule

// [sim/tb_motion_inhibit_limit_io.sv]
module tb_motion_inhibit_limit_io;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK, RST_N, WR, RD;
	logic [3:0] ADDR;
	logic [7:0] WDATA, RDATA, AXIS_INHIBIT, FWD_LIMIT, REV_LIMIT, INHIBIT_PIN, HALT;
	logic [7:0] fwd_cmd, rev_cmd, axis_cmd, halt_seen;
	int failures = 0;
	int checked = 0;

	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	mil_axis_model model (.clk(CLK), .fwd_cmd(fwd_cmd), .rev_cmd(rev_cmd), .inh_cmd(axis_cmd),
		.fwd_pin(FWD_LIMIT), .rev_pin(REV_LIMIT), .axis_inh(AXIS_INHIBIT));
	mil_top dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .AXIS_INHIBIT(AXIS_INHIBIT), .FWD_LIMIT(FWD_LIMIT),
		.REV_LIMIT(REV_LIMIT), .INHIBIT_PIN(INHIBIT_PIN), .HALT(HALT));

	// halt is a one-cycle pulse, so collect it rather than sample it
	always @(posedge CLK) begin
		if (!RST_N)
			halt_seen <= 8'h00;
		else
			halt_seen <= halt_seen | HALT;
	end

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 chk("rdata", exp, RDATA);
	endtask
	task pin(input logic [7:0] exp);
		repeat (2) @(posedge CLK);
		#1 chk("inhibit pin", exp, INHIBIT_PIN);
	endtask
	task lim(input logic [7:0] f, input logic [7:0] r);
		fwd_cmd <= f;
		rev_cmd <= r;
		repeat (4) @(posedge CLK);
		#1;
	endtask
	task stop_test;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		#100us;
		failures++;
		stop_test;
	end
	initial begin
		RST_N = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 4'h0;
		WDATA = 8'h00;
		fwd_cmd = 8'hff;
		rev_cmd = 8'hff;
		axis_cmd = 8'h00;
		repeat (3) @(posedge CLK);
		RST_N <= 1'b1;
		rd(mil_pkg::OFS_FWD_POL, 8'hff);
		rd(mil_pkg::OFS_REV_POL, 8'hff);
		rd(mil_pkg::OFS_INH_STATE, 8'h00);
		wr(mil_pkg::OFS_FORCE_ON, 8'hf2);
		wr(mil_pkg::OFS_APPLY, 8'h00);
		pin(8'hf2);
		// bit0 both set, bits 1, 3 and 4 forced off, the rest held
		wr(mil_pkg::OFS_FORCE_ON, 8'h01);
		wr(mil_pkg::OFS_FORCE_OFF, 8'h1b);
		wr(mil_pkg::OFS_APPLY, 8'h00);
		pin(8'he1);
		rd(mil_pkg::OFS_INH_STATE, 8'he1);
		// read-only and unmapped places
		wr(mil_pkg::OFS_INH_STATE, 8'h00);
		wr(4'hf, 8'h55);
		rd(4'hf, 8'h00);
		rd(mil_pkg::OFS_INH_STATE, 8'he1);
		wr(mil_pkg::OFS_INH_POL, 8'hff);
		pin(8'h1e);
		axis_cmd <= 8'h05;
		wr(mil_pkg::OFS_INH_AXIS_EN, 8'h0f);
		pin(8'h1a);
		wr(mil_pkg::OFS_FORCE_ON, 8'hff);
		wr(mil_pkg::OFS_FORCE_OFF, 8'h00);
		wr(mil_pkg::OFS_APPLY, 8'h00);
		pin(8'h0a);
		// limits: active low by default, limits not yet enabled
		lim(8'hfb, 8'hff);
		rd(mil_pkg::OFS_FWD_STAT, 8'h04);
		chk("halt", 8'h00, halt_seen);
		wr(mil_pkg::OFS_REV_POL, 8'h00);
		lim(8'hf9, 8'h06);
		rd(mil_pkg::OFS_REV_STAT, 8'h06);
		rd(mil_pkg::OFS_FWD_STAT, 8'h06);
		chk("halt", 8'h00, halt_seen);
		wr(mil_pkg::OFS_LIM_EN, 8'h01);
		lim(8'hf8, 8'h06);
		chk("halt", 8'h01, halt_seen);
		stop_test;
	end
endmodule
